// ### alu_selftest_input_injector.sv
// ALU self-test input injector: argument registers on Avalon-MM and the operand select.
// Assumes one clock, synchronous converter inputs, and a master that holds its request
// until it sees waitrequest low.
`timescale 1ns/1ps
`default_nettype none
`include "alu_selftest_consts.svh"

// Function
// - Self-test on: odd sample second conversion takes the odd second argument.
// - Self-test and oversampling: even sample first conversion takes even first argument.
// - Self-test and oversampling: even sample second conversion takes even second argument.
// - Stored arguments reach the ALU only while self-test is enabled.
// - Each argument is a 12-bit read/write field, zero after reset.
// - Enable sits at bit 15 of the odd first register; ALU takes register data.
// - Injected operands bypass calibration: unity gain, zero offset.
// - Enable ignored for on-demand calibration scans and automated balancing scans.
// - Self-test on: odd sample first conversion takes the odd first argument.
module alu_selftest_input_injector
  import alu_selftest_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // Avalon-MM slave
  input  wire logic [`BUS_ADDR_W-1:0]  address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [`BUS_DATA_W-1:0]  writedata,
  input  wire logic [`BUS_BE_W-1:0]    byteenable,
  output logic      [`BUS_DATA_W-1:0]  readdata,
  output logic                         waitrequest,
  // Converter side
  input  wire conv_in_t                conv_in,
  input  wire scan_ctx_t               scan_ctx,
  // ALU side
  output alu_in_t                      alu_in,
  output logic                         alu_selftest_mode
);

  // ---------------------------------------------------------------
  // Register storage and address decode
  // ---------------------------------------------------------------
  logic [`ARG_W-1:0]        arg_q [`NUM_ARGS];
  logic                     alu_selftest_enable_q;
  logic [`BUS_DATA_W-1:0]   readdata_q;
  logic                     waitrequest_q;
  logic [`NUM_ARGS-1:0]     hit;
  logic [`BUS_DATA_W-1:0]   rd_part [`NUM_ARGS];
  logic [7:0]               idx [`NUM_ARGS];
  wire  logic               commit_wr = write & ~waitrequest_q;
  wire  logic               take_req  = (read | write) & waitrequest_q;

  assign idx[`SLOT_ODD_FIRST]   = `IDX_ODD_FIRST;
  assign idx[`SLOT_ODD_SECOND]  = `IDX_ODD_SECOND;
  assign idx[`SLOT_EVEN_FIRST]  = `IDX_EVEN_FIRST;
  assign idx[`SLOT_EVEN_SECOND] = `IDX_EVEN_SECOND;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_ARGS; gi++) begin : g_arg
      logic [`ARG_W-1:0] arg_d;
      assign hit[gi] = (address == {idx[gi], `WORD_PAD});
      // Byte lanes above the field are dropped
      assign arg_d = {byteenable[`BE_HI] ? writedata[`ARG_MSB:`ARG_HI_LSB]
                                         : arg_q[gi][`ARG_MSB:`ARG_HI_LSB],
                      byteenable[`BE_LO] ? writedata[`ARG_LO_MSB:0]
                                         : arg_q[gi][`ARG_LO_MSB:0]};
      assign rd_part[gi] = hit[gi] ? {{(`BUS_DATA_W-`ARG_W){1'b0}}, arg_q[gi]}
                                   : `RD_ZERO;

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          arg_q[gi] <= `ARG_RST;
        end else if (commit_wr && hit[gi]) begin
          arg_q[gi] <= arg_d;
        end
      end
    end
  endgenerate

  wire logic en_wr = commit_wr & hit[`SLOT_ODD_FIRST] & byteenable[`BE_HI];

  wire logic [`BUS_DATA_W-1:0] en_word =
    hit[`SLOT_ODD_FIRST] ? (`BUS_DATA_W'(alu_selftest_enable_q) << `EN_BIT) : `RD_ZERO;

  wire logic [`BUS_DATA_W-1:0] rd_word = rd_part[0] | rd_part[1] | rd_part[2]
                                       | rd_part[3] | en_word;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alu_selftest_enable_q <= `EN_RST;
    end else if (en_wr) begin
      alu_selftest_enable_q <= writedata[`EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Bus handshake: one wait cycle, then a single-cycle answer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest_q <= 1'b1;
      readdata_q    <= `RD_ZERO;
    end else begin
      waitrequest_q <= ~take_req;
      if (take_req && read) begin
        readdata_q <= rd_word;
      end
    end
  end

  assign readdata    = readdata_q;
  assign waitrequest = waitrequest_q;

  // ---------------------------------------------------------------
  // Operand select toward the ALU
  // ---------------------------------------------------------------
  alu_in_t alu_d;
  alu_in_t alu_q;
  logic    mode_q;

  wire logic inject_ok = alu_selftest_enable_q & ~scan_ctx.on_demand_cal
                       & ~scan_ctx.auto_balancing;
  wire logic inject_even = inject_ok & scan_ctx.oversampling & ~conv_in.odd_sample;
  wire logic inject_odd  = inject_ok & conv_in.odd_sample;
  wire logic inject      = inject_odd | inject_even;

  wire logic [1:0] slot = conv_in.odd_sample
    ? (conv_in.second_conv ? `SLOT_ODD_SECOND : `SLOT_ODD_FIRST)
    : (conv_in.second_conv ? `SLOT_EVEN_SECOND : `SLOT_EVEN_FIRST);

  assign alu_d.valid      = conv_in.valid;
  assign alu_d.cal_bypass = inject;
  assign alu_d.data       = inject ? arg_q[slot] : conv_in.data;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alu_q  <= '0;
      mode_q <= 1'b0;
    end else begin
      alu_q  <= alu_d;
      mode_q <= inject_ok;
    end
  end

  assign alu_in            = alu_q;
  assign alu_selftest_mode = mode_q;

endmodule : alu_selftest_input_injector
`default_nettype wire

// ### alu_selftest_consts.svh
// Constants for the ALU self-test input injector: register map, field layout, reset values.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
`ifndef ALU_SELFTEST_CONSTS_SVH
`define ALU_SELFTEST_CONSTS_SVH

// ---------------------------------------------------------------
// Bus geometry
// ---------------------------------------------------------------
`define BUS_DATA_W       32
`define BUS_ADDR_W       10
`define BUS_BE_W         4
`define WORD_PAD         2'b00

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_ODD_FIRST    8'h67
`define IDX_ODD_SECOND   8'h68
`define IDX_EVEN_FIRST   8'h69
`define IDX_EVEN_SECOND  8'h6A
`define NUM_ARGS         4

// ---------------------------------------------------------------
// Field layout and reset values
// ---------------------------------------------------------------
`define ARG_W            12
`define ARG_LO_MSB       7
`define ARG_HI_LSB       8
`define ARG_MSB          11
`define EN_BIT           15
`define ARG_RST          12'h000
`define EN_RST           1'h0
`define RD_ZERO          32'h0000_0000
`define BE_LO            0
`define BE_HI            1

// ---------------------------------------------------------------
// Argument slots in the storage array
// ---------------------------------------------------------------
`define SLOT_ODD_FIRST   2'h0
`define SLOT_ODD_SECOND  2'h1
`define SLOT_EVEN_FIRST  2'h2
`define SLOT_EVEN_SECOND 2'h3

`endif

// ### alu_selftest_pkg.sv
// Types for the ALU self-test input injector.
// Assumes alu_selftest_consts.svh is on the include path.
`include "alu_selftest_consts.svh"

package alu_selftest_pkg;

  // One converter result offered to the ALU, with its place in the sample sequence
  typedef struct packed {
    logic               valid;
    logic               odd_sample;
    logic               second_conv;
    logic [`ARG_W-1:0]  data;
  } conv_in_t;

  // Operand handed to the ALU and whether calibration must be bypassed
  typedef struct packed {
    logic               valid;
    logic               cal_bypass;
    logic [`ARG_W-1:0]  data;
  } alu_in_t;

  // Scan context that decides whether injection is allowed
  typedef struct packed {
    logic               oversampling;
    logic               on_demand_cal;
    logic               auto_balancing;
  } scan_ctx_t;

endpackage : alu_selftest_pkg

// ### alu_selftest_chk.sv
// Checker for the ALU self-test injector: bus timing and operand selection.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "alu_selftest_consts.svh"
module alu_selftest_chk
  import alu_selftest_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic [`BUS_ADDR_W-1:0]  address,
  input wire logic                    read,
  input wire logic                    write,
  input wire logic [`BUS_DATA_W-1:0]  writedata,
  input wire logic [`BUS_BE_W-1:0]    byteenable,
  input wire logic [`BUS_DATA_W-1:0]  readdata,
  input wire logic                    waitrequest,
  input wire conv_in_t                conv_in,
  input wire scan_ctx_t               scan_ctx,
  input wire alu_in_t                 alu_in,
  input wire logic                    alu_selftest_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_odd_steady;
    alu_selftest_mode && $stable(scan_ctx) && $past(waitrequest);
  endsequence
  property p_wait_one; s_req |=> !waitrequest; endproperty
  property p_wait_pulse; !waitrequest |=> waitrequest; endproperty
  property p_upper_zero; readdata[31:16] == 16'h0000 && readdata[14:12] == 3'h0; endproperty
  property p_pass; $past(nrst) && !alu_in.cal_bypass |-> alu_in.data == $past(conv_in.data);
  endproperty
  property p_ctx_block;
    $past(nrst && (scan_ctx.on_demand_cal || scan_ctx.auto_balancing)) |-> !alu_in.cal_bypass;
  endproperty
  property p_even_plain;
    $past(nrst && !conv_in.odd_sample && !scan_ctx.oversampling) |-> !alu_in.cal_bypass;
  endproperty
  property p_bypass_mode; alu_in.cal_bypass |-> alu_selftest_mode; endproperty
  property p_odd_inject;
    s_odd_steady and conv_in.valid && conv_in.odd_sample |=> alu_in.cal_bypass;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("request not answered");
  a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");
  a_upper_zero: assert property (p_upper_zero) else $error("unused bits set");
  a_pass: assert property (p_pass) else $error("converter data lost");
  a_ctx_block: assert property (p_ctx_block) else $error("injected in blocked scan");
  a_even_plain: assert property (p_even_plain) else $error("even injected");
  a_bypass_mode: assert property (p_bypass_mode) else $error("bypass without mode");
  a_odd_inject: assert property (p_odd_inject) else $error("odd not injected");
endmodule : alu_selftest_chk
bind alu_selftest_input_injector alu_selftest_chk u_chk (.clk(clk), .nrst(nrst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .conv_in(conv_in), .scan_ctx(scan_ctx), .alu_in(alu_in),
  .alu_selftest_mode(alu_selftest_mode));
`default_nettype wire

// ### alu_selftest_input_injector_test.sv
// Testbench for the ALU self-test injector: registers over Avalon-MM, operand select.
// Drives every port itself; no far-side model.
`timescale 1ns/1ps
`default_nettype none
`include "alu_selftest_consts.svh"
module alu_selftest_input_injector_test;
  import alu_selftest_pkg::*;
  logic                   clk, nrst, read, write, waitrequest, alu_selftest_mode;
  logic [`BUS_ADDR_W-1:0] address;
  logic [`BUS_DATA_W-1:0] writedata, readdata;
  logic [`BUS_BE_W-1:0]   byteenable;
  conv_in_t               conv_in;
  scan_ctx_t              scan_ctx;
  alu_in_t                alu_in;
  int                     n_errors = 0, n_compared = 0;
  alu_selftest_input_injector dut (.clk(clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .conv_in(conv_in), .scan_ctx(scan_ctx), .alu_in(alu_in),
    .alu_selftest_mode(alu_selftest_mode));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task end_of_test;
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One bus cycle; a read compares its data with e
  task acc(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be,
           input logic [31:0] e);
    @(posedge clk);
    address <= a; write <= w; read <= !w; writedata <= d; byteenable <= be;
    do @(posedge clk); while (waitrequest !== 1'b0);
    if (!w) chk("readdata", e, readdata);
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc
  // Offer one conversion and judge the operand
  task conv(input logic [2:0] ctx, input logic o, input logic s, input logic [11:0] e,
            input logic byp);
    @(posedge clk);
    scan_ctx <= ctx;
    conv_in <= {1'b1, o, s, 12'h5A5};
    repeat (2) @(posedge clk);
    #1;
    chk("alu_in.data", {20'h0, e}, {20'h0, alu_in.data});
    chk("cal_bypass", {31'h0, byp}, {31'h0, alu_in.cal_bypass});
    chk("alu_in.valid", 32'h0000_0001, {31'h0, alu_in.valid});
  endtask : conv
  task t_regs;
    for (int i = 0; i < 5; i++) acc(1'b0, 10'h19C + 10'(4 * i), 0, 4'hF, 0);
    acc(1'b1, 10'h1A0, 32'hFFFF_FFFF, 4'hF, 0);
    acc(1'b0, 10'h1A0, 0, 4'hF, 32'h0000_0FFF);
    acc(1'b1, 10'h1AC, 32'h0000_0123, 4'hF, 0);
    acc(1'b0, 10'h1AC, 0, 4'hF, 32'h0000_0000);
    acc(1'b1, 10'h1A0, 32'h0000_0B22, 4'hF, 0);
    acc(1'b1, 10'h1A4, 32'h0000_0C33, 4'hF, 0);
    acc(1'b1, 10'h1A8, 32'h0000_0D44, 4'hF, 0);
    acc(1'b1, 10'h1A8, 32'hFFFF_FFFF, 4'h1, 0);
    acc(1'b0, 10'h1A8, 0, 4'hF, 32'h0000_0DFF);
    acc(1'b1, 10'h19C, 32'hFFFF_FA11, 4'hF, 0);
    acc(1'b0, 10'h19C, 0, 4'hF, 32'h0000_8A11);
  endtask : t_regs
  task t_inject;
    conv(3'b100, 1'b1, 1'b0, 12'hA11, 1'b1);
    conv(3'b100, 1'b1, 1'b1, 12'hB22, 1'b1);
    conv(3'b100, 1'b0, 1'b0, 12'hC33, 1'b1);
    conv(3'b100, 1'b0, 1'b1, 12'hDFF, 1'b1);
    chk("alu_selftest_mode", 1, {31'h0, alu_selftest_mode});
  endtask : t_inject
  task t_blocked;
    conv(3'b000, 1'b0, 1'b1, 12'h5A5, 1'b0);
    conv(3'b110, 1'b1, 1'b0, 12'h5A5, 1'b0);
    conv(3'b101, 1'b1, 1'b1, 12'h5A5, 1'b0);
    acc(1'b1, 10'h19C, 32'h0000_0000, 4'hF, 0);
    conv(3'b100, 1'b1, 1'b1, 12'h5A5, 1'b0);
    chk("alu_selftest_mode", 0, {31'h0, alu_selftest_mode});
  endtask : t_blocked
  initial begin
    nrst = 1'b0; read = 1'b0; write = 1'b0; address = '0; writedata = '0;
    byteenable = 4'hF; conv_in = '0; scan_ctx = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_inject;
    t_blocked;
    end_of_test;
  end
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
endmodule : alu_selftest_input_injector_test
`default_nettype wire
